/* logic/scte_top.sv */
/*
 Smart card transmit channel: register file, bit timer, frame
 shifter, transmit-end and data-empty flags, interrupt logic.
 Assumes a Wishbone classic master on clk_i and an error-signal
 status level from the receive side on the same clock.
*/
// Register access over Wishbone and the register offsets were chosen for this implementation.
// What this block does
// - In smart card mode the transmit-end flag stays set while transmit enable is 0.
// - In smart card mode transmit-end sets after the guard interval if error status is 0 and no new data came.
// - Writing transmit data while transmit enable is 1 clears transmit-end.
// - Three select bits pick 93,128,186,512,32,64,372 or 256 base clocks per bit.
// - Smart card mode select 1 runs smart card framing, 0 the plain serial modes.
// - Data-empty sets when a byte moves to the shifter and clears on a data write.
`timescale 1ns/1ps
module scte_top
   import scte_pkg::*;
#(
   parameter logic [3:0] GUARD_BITS = GUARD_BITS_DEF
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic err_sig_i,
   output logic txd_o,
   output logic irq_o
);
   // ==========================================================
   // Helpers
   // Cycles per bit from the three select bits
   function automatic logic [9:0] bit_cycles(input logic [2:0] s);
      logic [9:0] c;
      c = S_000;
      case (s)
         3'h1: c = S_001;
         3'h2: c = S_010;
         3'h3: c = S_011;
         3'h4: c = S_100;
         3'h5: c = S_101;
         3'h6: c = S_110;
         3'h7: c = S_111;
         default: c = S_000;
      endcase
      return c;
   endfunction

   // ==========================================================
   // Bus slave
   logic ack_r, ack_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic wr_go;
   logic [7:0] smr_r, scr_r, smart_card_mode_control_r, tdr_r;
   logic tx_data_empty_flag_r, tx_end_flag_r, ers_q_r;
   logic [2:0] ist_r, imsk_r;

   // Writes land on the edge where ack is seen high
   assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];

   // One wait cycle, ack for one cycle; read data captured on reads only,
   // so a write leaves the last read value standing
   always_comb
   begin
      ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
      rd_nxt = rd_r;
      if (ack_nxt && !wb_we_i)
      begin
         rd_nxt = 32'h0000_0000;
         case (wb_adr_i)
            OFS_SMR: rd_nxt[7:0] = smr_r;
            OFS_SCR: rd_nxt[7:0] = scr_r;
            OFS_TDR: rd_nxt[7:0] = tdr_r;
            OFS_SSR:
            begin
               rd_nxt[SSR_TX_DATA_EMPTY_FLAG] = tx_data_empty_flag_r;
               rd_nxt[SSR_ERS] = err_sig_i;
               rd_nxt[SSR_TX_END_FLAG] = tx_end_flag_r;
            end
            OFS_SMART_CARD_MODE_CONTROL: rd_nxt[7:0] = smart_card_mode_control_r;
            OFS_IST: rd_nxt[2:0] = ist_r;
            OFS_IMSK: rd_nxt[2:0] = imsk_r;
            default: rd_nxt = 32'h0000_0000; // Unmapped reads zero
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
         rd_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r <= ack_nxt;
         rd_r <= rd_nxt;
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rd_r;

   // ==========================================================
   // Configuration registers
   logic [7:0] smr_nxt, scr_nxt, smart_card_mode_control_nxt, imsk_nxt8;
   logic te, smart_card_mode_select;
   logic [9:0] s_cyc;

   always_comb
   begin
      smr_nxt = smr_r;
      scr_nxt = scr_r;
      smart_card_mode_control_nxt = smart_card_mode_control_r;
      imsk_nxt8 = {5'h00, imsk_r};
      if (wr_go)
      begin
         case (wb_adr_i)
            OFS_SMR: smr_nxt = wb_dat_i[7:0];
            OFS_SCR: scr_nxt = wb_dat_i[7:0];
            OFS_SMART_CARD_MODE_CONTROL: smart_card_mode_control_nxt = wb_dat_i[7:0];
            OFS_IMSK: imsk_nxt8 = {5'h00, wb_dat_i[2:0]};
            default: smr_nxt = smr_r;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         smr_r <= RST_SMR;
         scr_r <= RST_SCR;
         smart_card_mode_control_r <= RST_SMART_CARD_MODE_CONTROL;
         imsk_r <= 3'h0;
      end
      else
      begin
         smr_r <= smr_nxt;
         scr_r <= scr_nxt;
         smart_card_mode_control_r <= smart_card_mode_control_nxt;
         imsk_r <= imsk_nxt8[2:0];
      end
   end

   assign te = scr_r[SCR_TE];
   assign smart_card_mode_select = smart_card_mode_control_r[SMART_CARD_MODE_CONTROL_SMART_CARD_MODE_SELECT];
   // Upper select bit from mode control, lower two from serial mode
   assign s_cyc = bit_cycles({smart_card_mode_control_r[SMART_CARD_MODE_CONTROL_BCP_HI],
                              smr_r[SMR_BCP_LO+1:SMR_BCP_LO]});

   // ==========================================================
   // Transmitter
   scte_state_t st_r, st_nxt;
   logic [9:0] div_r, div_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [9:0] tsr_r, tsr_nxt;
   logic [7:0] tdr_nxt;
   logic tx_data_empty_flag_nxt, tx_end_flag_nxt, txd_r, txd_nxt;
   logic wr_tdr, tick;

   assign wr_tdr = wr_go & (wb_adr_i == OFS_TDR);
   // A select change mid-frame takes effect at once; software should
   // only change it with transmit disabled
   assign tick = (div_r >= s_cyc - 10'd1);

   always_comb
   begin
      st_nxt = st_r;
      div_nxt = div_r;
      bit_nxt = bit_r;
      tsr_nxt = tsr_r;
      tdr_nxt = tdr_r;
      tx_data_empty_flag_nxt = tx_data_empty_flag_r;
      tx_end_flag_nxt = tx_end_flag_r;
      txd_nxt = txd_r;
      if (st_r != ST_IDLE)
         div_nxt = tick ? 10'd0 : div_r + 10'd1;
      case (st_r)
         ST_IDLE:
         begin
            if (te && !tx_data_empty_flag_r)
            begin
               // Start, eight data bits LSB first, even parity
               tsr_nxt = {^tdr_r, tdr_r, 1'b0};
               tx_data_empty_flag_nxt = 1'b1;
               div_nxt = 10'd0;
               bit_nxt = 4'h0;
               txd_nxt = 1'b0;
               st_nxt = ST_SHIFT;
            end
         end
         ST_SHIFT:
         begin
            if (tick)
            begin
               if (bit_r == FRAME_BITS - 4'h1)
               begin
                  txd_nxt = 1'b1;
                  bit_nxt = 4'h0;
                  if (smart_card_mode_select)
                     st_nxt = ST_GUARD;
                  else
                  begin
                     // Plain modes: end as the last bit goes out
                     st_nxt = ST_IDLE;
                     if (tx_data_empty_flag_r && !wr_tdr)
                        tx_end_flag_nxt = 1'b1;
                  end
               end
               else
               begin
                  tsr_nxt = {1'b1, tsr_r[9:1]};
                  txd_nxt = tsr_r[1];
                  bit_nxt = bit_r + 4'h1;
               end
            end
         end
         ST_GUARD:
         begin
            if (tick)
            begin
               bit_nxt = bit_r + 4'h1;
               if (bit_r >= GUARD_BITS - 4'h1)
               begin
                  st_nxt = ST_IDLE;
                  if (!err_sig_i && tx_data_empty_flag_r && !wr_tdr)
                     tx_end_flag_nxt = 1'b1;
               end
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      // Data write last so it beats a same-cycle transfer
      if (wr_tdr)
      begin
         tdr_nxt = wb_dat_i[7:0];
         tx_data_empty_flag_nxt = 1'b0;
         if (te)
            tx_end_flag_nxt = 1'b0;
      end
      // Disabled transmitter parks the line and holds end set
      if (!te)
      begin
         st_nxt = ST_IDLE;
         txd_nxt = 1'b1;
         tx_end_flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r <= ST_IDLE;
         div_r <= 10'd0;
         bit_r <= 4'h0;
         tsr_r <= 10'h3ff;
         tdr_r <= RST_TDR;
         tx_data_empty_flag_r <= RST_TX_DATA_EMPTY_FLAG;
         tx_end_flag_r <= RST_TX_END_FLAG;
         txd_r <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
         div_r <= div_nxt;
         bit_r <= bit_nxt;
         tsr_r <= tsr_nxt;
         tdr_r <= tdr_nxt;
         tx_data_empty_flag_r <= tx_data_empty_flag_nxt;
         tx_end_flag_r <= tx_end_flag_nxt;
         txd_r <= txd_nxt;
      end
   end
   assign txd_o = txd_r;

   // ==========================================================
   // Interrupts: rising flags are sticky, write one to clear
   logic [2:0] ist_nxt, ev;
   logic irq_r, irq_nxt;

   always_comb
   begin
      ev = 3'h0;
      ev[IRQ_TX_DATA_EMPTY_FLAG] = tx_data_empty_flag_nxt & ~tx_data_empty_flag_r;
      ev[IRQ_TX_END_FLAG] = tx_end_flag_nxt & ~tx_end_flag_r;
      ev[IRQ_ERS] = err_sig_i & ~ers_q_r;
      ist_nxt = ist_r;
      if (wr_go && wb_adr_i == OFS_IST)
         ist_nxt = ist_r & ~wb_dat_i[2:0];
      // Set after clear so an event in the clear cycle survives
      ist_nxt = ist_nxt | ev;
      irq_nxt = |(ist_nxt & imsk_nxt8[2:0]);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ist_r <= 3'h0;
         ers_q_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         ist_r <= ist_nxt;
         ers_q_r <= err_sig_i;
         irq_r <= irq_nxt;
      end
   end
   assign irq_o = irq_r;
endmodule

/* logic/scte_pkg.sv */
/*
 Shared constants of the smart card transmit block: register offsets,
 field positions, reset values and the cycles-per-bit table.
 Assumes a Wishbone classic master with 32-bit data and byte addresses.
*/
package scte_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [4:0] OFS_SMR = 5'h00;
   localparam logic [4:0] OFS_SCR = 5'h04;
   localparam logic [4:0] OFS_TDR = 5'h08;
   localparam logic [4:0] OFS_SSR = 5'h0c;
   localparam logic [4:0] OFS_SMART_CARD_MODE_CONTROL = 5'h10;
   localparam logic [4:0] OFS_IST = 5'h14;
   localparam logic [4:0] OFS_IMSK = 5'h18;
   // ==========================================================
   // Field positions
   localparam int SMR_BCP_LO = 0;
   localparam int SCR_TE = 5;
   localparam int SSR_TX_DATA_EMPTY_FLAG = 7;
   localparam int SSR_ERS = 4;
   localparam int SSR_TX_END_FLAG = 2;
   localparam int SMART_CARD_MODE_CONTROL_SMART_CARD_MODE_SELECT = 0;
   localparam int SMART_CARD_MODE_CONTROL_BCP_HI = 7;
   localparam int IRQ_TX_DATA_EMPTY_FLAG = 0;
   localparam int IRQ_TX_END_FLAG = 1;
   localparam int IRQ_ERS = 2;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_SMR = 8'h00;
   localparam logic [7:0] RST_SCR = 8'h00;
   localparam logic [7:0] RST_SMART_CARD_MODE_CONTROL = 8'h00;
   localparam logic [7:0] RST_TDR = 8'hff;
   localparam logic RST_TX_DATA_EMPTY_FLAG = 1'b1;
   localparam logic RST_TX_END_FLAG = 1'b1;
   // ==========================================================
   // Frame and timing counts
   localparam logic [3:0] FRAME_BITS = 4'ha;
   localparam logic [3:0] GUARD_BITS_DEF = 4'h2;
   localparam logic [9:0] S_000 = 10'd93;
   localparam logic [9:0] S_001 = 10'd128;
   localparam logic [9:0] S_010 = 10'd186;
   localparam logic [9:0] S_011 = 10'd512;
   localparam logic [9:0] S_100 = 10'd32;
   localparam logic [9:0] S_101 = 10'd64;
   localparam logic [9:0] S_110 = 10'd372;
   localparam logic [9:0] S_111 = 10'd256;
   // ==========================================================
   // Transmitter states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_GUARD = 3'b100
   } scte_state_t;
endpackage

/* bench/scte_top_asserts.sv */
/*
 Port checker for the smart card transmit block.
 Assumes one clock, clk_i, and synchronous active-high rst_i.
*/
`timescale 1ns/1ps
module scte_top_asserts
   import scte_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic err_sig_i,
   input wire logic txd_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A request is taken only while no ack is out
   wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // ==========================================================
   // Bus handshake
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   ack_answer_a: assert property (req |=> wb_ack_o)
      else $error("ack late");
   ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   unmapped_a: assert property (req && !wb_we_i && wb_adr_i == 5'h1c |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   dat_hold_a: assert property (!(req && !wb_we_i) |=> $stable(wb_dat_o))
      else $error("read data moved");
   // ==========================================================
   // Line and interrupt; every bit is at least 32 base clocks
   txd_hold_a: assert property ($changed(txd_o) |=> $stable(txd_o) [*8])
      else $error("line bit too short");
   irq_mask_a: assert property (req && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_IMSK
      && wb_dat_i[7:0] == 8'h00 |-> ##[1:4] !irq_o)
      else $error("irq stays with mask cleared");
endmodule
bind scte_top scte_top_asserts u_scte_top_asserts (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .err_sig_i(err_sig_i), .txd_o(txd_o), .irq_o(irq_o));

/* bench/scte_card.sv */
/*
 Behavioural smart card on the serial line.
 Assumes the line is sampled on the block's own clock.
*/
`timescale 1ns/1ps
module scte_card
(
   input wire logic clk_i,
   input wire logic txd_i,
   input wire logic err_req_i,
   output logic err_o,
   output int width_o,
   output logic done_o
);
   int run_r = 0;
   // Error level only when the bench asks, so a bad character is deliberate
   assign err_o = err_req_i;
   // Length of each low run; the first of a frame begins with the start bit
   always @(posedge clk_i)
   begin
      done_o <= 1'b0;
      if (txd_i === 1'b0)
         run_r <= run_r + 1;
      else
      begin
         if (run_r != 0)
         begin
            width_o <= run_r;
            done_o <= 1'b1;
         end
         run_r <= 0;
      end
   end
endmodule

/* bench/scte_top_tb_top.sv */
/*
 Self-checking bench for the smart card transmit block.
 Assumes the card model and the bound checker.
*/
`timescale 1ns/1ps
module scte_top_tb_top;
   import scte_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [4:0] wb_adr_i = 5'h00;
   logic [3:0] wb_sel_i = 4'h1;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic [31:0] q;
   logic wb_ack_o, err_req = 1'b0, err_sig, txd, irq, done;
   int width, errors = 0, n_compared = 0;
   int s_tab[8] = '{93, 128, 186, 512, 32, 64, 372, 256};
   // ==========================================================
   // Clock and instances
   always #25 clk_i = ~clk_i;
   scte_top u_scte_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .err_sig_i(err_sig), .txd_o(txd), .irq_o(irq));
   scte_card u_scte_card (.clk_i(clk_i), .txd_i(txd), .err_req_i(err_req),
      .err_o(err_sig), .width_o(width), .done_o(done));
   // ==========================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One classic cycle; read data is taken at the ack edge only
   task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h0, d};
      // Wait for the answer; only the watchdog ends a hung cycle
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
         @(posedge clk_i);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic close_out;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      bus(OFS_SSR, 1'b0, 8'h00);
      chk("status at reset", q, 32'h84);
      bus(5'h1c, 1'b0, 8'h00);
      chk("unmapped read", q, 32'h0);
   endtask
   // Every select code, a one-byte frame each, start bit timed by the card
   task automatic t_sel;
      int i, n;
      for (i = 0; i < 8; i++)
      begin
         bus(OFS_SMR, 1'b1, {6'h0, i[1:0]});
         bus(OFS_SMART_CARD_MODE_CONTROL, 1'b1, {i[2], 7'h01});
         bus(OFS_SCR, 1'b1, 8'h20);
         bus(OFS_IMSK, 1'b1, 8'h02);
         bus(OFS_TDR, 1'b1, 8'h01);
         bus(OFS_SSR, 1'b0, 8'h00);
         chk("tx end after write", q[SSR_TX_END_FLAG], 32'h0);
         for (n = 0; n < 600 && done !== 1'b1; n++) @(posedge clk_i);
         chk("bit width", width, s_tab[i]);
         // Byte 01 LSB first: d1 to d7 form one low run of seven bits
         @(posedge clk_i);
         for (n = 0; n < 5000 && done !== 1'b1; n++) @(posedge clk_i);
         chk("d1 to d7 width", width, 7 * s_tab[i]);
         for (n = 0; n < 9000 && irq !== 1'b1; n++) @(posedge clk_i);
         bus(OFS_SSR, 1'b0, 8'h00);
         chk("status after guard", q, 32'h84);
         bus(OFS_IST, 1'b1, 8'h07);
         repeat (2) @(posedge clk_i);
         chk("irq cleared", irq, 32'h0);
      end
   endtask
   // Error level during the frame keeps tx end low until enable drops
   task automatic t_err;
      int n;
      bus(OFS_SMR, 1'b1, 8'h00);
      bus(OFS_SMART_CARD_MODE_CONTROL, 1'b1, 8'h81);
      err_req <= 1'b1;
      bus(OFS_TDR, 1'b1, 8'h01);
      for (n = 0; n < 600 && done !== 1'b1; n++) @(posedge clk_i);
      repeat (448) @(posedge clk_i);
      bus(OFS_SSR, 1'b0, 8'h00);
      chk("tx end held by error", q, 32'h90);
      bus(OFS_SCR, 1'b1, 8'h00);
      bus(OFS_SSR, 1'b0, 8'h00);
      chk("tx end with enable off", q, 32'h94);
      err_req <= 1'b0;
      bus(OFS_TDR, 1'b1, 8'haa);
      bus(OFS_SSR, 1'b0, 8'h00);
      chk("write with enable off", q, 32'h04);
      bus(OFS_IMSK, 1'b1, 8'h00);
   endtask
   // Plain mode: pending byte aa leaves on enable, then a fresh byte whose
   // tx end must come at frame end, well before a guard would finish
   task automatic t_plain;
      int n;
      bus(OFS_SMART_CARD_MODE_CONTROL, 1'b1, 8'h00);
      bus(OFS_SCR, 1'b1, 8'h20);
      for (n = 0; n < 600 && done !== 1'b1; n++) @(posedge clk_i);
      chk("start and d0 width", width, 2 * s_tab[0]);
      repeat (800) @(posedge clk_i);
      bus(OFS_TDR, 1'b1, 8'h01);
      for (n = 0; n < 600 && done !== 1'b1; n++) @(posedge clk_i);
      repeat (860) @(posedge clk_i);
      bus(OFS_SSR, 1'b0, 8'h00);
      chk("plain tx end", q, 32'h84);
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_sel;
      t_err;
      t_plain;
      close_out;
   end
   initial
   begin
      repeat (60000) @(posedge clk_i);
      errors++;
      close_out;
   end
endmodule
